/* core/pci_image_translate_cfg_gen.sv */
`timescale 1ns/10ps
// Summary of operation
// R1 - Block codes 1011..1111 give 128M..2G images, comparing AD31-27 down to AD31.
// R2 - Command mode counts only toward the other PCI bus; memory mode allows bursts.
// R3 - I/O mode issues I/O commands, 4 bytes at most, retry after each beat.
// R4 - Mode 0 reads 8 bytes min; mode 1 is I/O, or 4-byte memory read.
// R5 - Prefetch keep and prefetch amount apply only in memory command mode.
// R6 - Prefetch amount codes 000..100 fetch 8..128 bytes; 101..111 reserved.
// R7 - Translation enable substitutes upper address bits covered by the block size.
// R8 - Translation field may change mid-transaction; software holds all else steady.
// R9 - Each of seven master-select bits claims or rejects that master's cycles.
// R10 - Master decode applies only with arbiter enable and image decode enable set.
// R11 - Select bits 1..7 map to pairs 1..7; pairs 5..7 need primary assignment.
// R12 - Configuration info holds bus, device, function, register numbers and type.
// R13 - Type 1 puts the whole configuration info word on the address lines.
// R14 - Type 0 drives one IDSEL line from the device number, none above 10100.
// R15 - Type 0 drives function on 10:8, register on 7:2, zeros on 1:0.
// R16 - Single-bus variant omits configuration info; the location reads as reserved.
// R17 - Block codes 0000..1010 give 64k..64M images comparing AD31-16 to AD31-26.
// R18 - Data register write makes a posted config write; a read, a delayed read.
module pci_image_translate_cfg_gen #(
  parameter int NUM_IMAGES = 4,
  parameter bit SINGLE_BUS = 1'b0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic primary_arbiter_enable_i,
  input wire logic shared_pair5_assign_i,
  input wire logic shared_pair6_assign_i,
  input wire logic shared_pair7_assign_i,
  input wire logic dec_req_i,
  input wire logic [1:0] dec_image_i,
  input wire logic [31:0] dec_addr_i,
  input wire logic [2:0] dec_master_i,
  input wire logic [3:0] image_block_size_i,
  input wire logic dest_is_pci_i,
  input wire logic command_mode_i,
  input wire logic four_byte_read_i,
  input wire logic prefetch_keep_i,
  input wire logic [2:0] prefetch_amount_i,
  input wire logic translation_enable_i,
  input wire logic master_decode_enable_i,
  output logic dec_valid_o,
  output logic dec_claim_o,
  output logic [31:0] dec_addr_o,
  output logic dec_io_cmd_o,
  output logic dec_burst_ok_o,
  output logic [3:0] dec_min_read_o,
  output logic [3:0] dec_max_bytes_o,
  output logic dec_prefetch_keep_o,
  output logic [7:0] dec_prefetch_bytes_o,
  output logic dec_prefetch_reserved_o,
  output logic cfg_start_o,
  output logic cfg_write_o,
  output logic cfg_type1_o,
  output logic [31:0] cfg_addr_o
);

  generate
    if (NUM_IMAGES != 4) begin : g_bad_images
      $error("NUM_IMAGES must be 4 to match the register map.");
    end
  endgenerate

  typedef struct packed {
    logic [3:0][15:0] translation_field;
    logic [3:0][6:0] mqual;
    logic [31:0] conf;
    logic [31:0] rdata;
    logic rvalid;
    logic dvalid;
    logic claim;
    logic [31:0] daddr;
    logic io_cmd;
    logic burst_ok;
    logic [3:0] min_read;
    logic [3:0] max_bytes;
    logic pf_keep;
    logic [7:0] pf_bytes;
    logic pf_resv;
    logic cstart;
    logic cwrite;
    logic ctype1;
    logic [31:0] caddr;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [31:0] block_mask;
  logic [31:0] idsel;
  logic [4:0] target_device_number;
  logic [3:0] image_hit;
  logic cfg_info_hit;
  logic cfg_data_hit;

  assign target_device_number = st_r.conf[pci_image_translate_cfg_gen_pkg::DEVICE_NUMBER_LSB +:
                             pci_image_translate_cfg_gen_pkg::DEVICE_NUMBER_W];

  // Upper bits compared and translated, from AD31 down to AD16 plus the block code.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_mask
      if (gi < pci_image_translate_cfg_gen_pkg::BLOCK_BASE_BIT) begin : g_low
        assign block_mask[gi] = 1'b0;
      end else begin : g_high
        assign block_mask[gi] = (5'(gi - pci_image_translate_cfg_gen_pkg::BLOCK_BASE_BIT)
                                 >= {1'b0, image_block_size_i}); // R1 R17
      end
    end
  endgenerate

  // IDSEL pattern on lines 31:11: one-hot for devices up to 10100, all zero above.
  generate
    for (gi = 0; gi < 32; gi++) begin : g_idsel
      if (gi >= pci_image_translate_cfg_gen_pkg::IDSEL_HIGH_BASE) begin : g_hi
        assign idsel[gi] = (target_device_number ==
          5'(gi - pci_image_translate_cfg_gen_pkg::IDSEL_HIGH_BASE)); // R14
      end else if (gi >= pci_image_translate_cfg_gen_pkg::IDSEL_LOW_BASE) begin : g_lo
        assign idsel[gi] = (target_device_number == 5'(gi - pci_image_translate_cfg_gen_pkg::IDSEL_LOW_BASE
          + 16)); // R14
      end else begin : g_none
        assign idsel[gi] = 1'b0;
      end
    end
  endgenerate

  // Register address decode, one comparator per image.
  generate
    for (gi = 0; gi < 4; gi++) begin : g_image_hit
      assign image_hit[gi] = (reg_addr_i ==
        pci_image_translate_cfg_gen_pkg::IMAGE0_TRANSLATION_ADDRESS_OFS + 12'(16 * gi));
    end
  endgenerate

  // The configuration registers are absent in the single-bus variant.
  assign cfg_info_hit = !SINGLE_BUS &&
    (reg_addr_i == pci_image_translate_cfg_gen_pkg::CONFIG_CYCLE_INFO_OFS); // R16
  assign cfg_data_hit = !SINGLE_BUS &&
    (reg_addr_i == pci_image_translate_cfg_gen_pkg::CONFIG_CYCLE_DATA_OFS); // R16

  always_comb begin
    logic mem_mode;
    logic [15:0] translation_field_sel;
    logic [6:0] mq_sel;
    logic [31:0] sub_addr;
    logic qualified;
    logic pair_on_primary;
    logic [31:0] cfg_word;
    mem_mode = 1'b1;
    translation_field_sel = 16'h0000;
    mq_sel = 7'h00;
    sub_addr = 32'h0000_0000;
    qualified = 1'b1;
    pair_on_primary = 1'b1;
    cfg_word = 32'h0000_0000;
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.dvalid = 1'b0;
    st_nxt.cstart = 1'b0;

    // Register writes.
    if (reg_wr_i) begin
      for (int i = 0; i < 4; i++) begin
        if (image_hit[i]) begin
          st_nxt.translation_field[i] = reg_wdata_i[pci_image_translate_cfg_gen_pkg::TRANSLATION_FIELD_LSB +:
                                        pci_image_translate_cfg_gen_pkg::TRANSLATION_FIELD_W];
          st_nxt.mqual[i] = reg_wdata_i[pci_image_translate_cfg_gen_pkg::MASTER_QUALIFY_LSB +:
                                        pci_image_translate_cfg_gen_pkg::MASTER_QUALIFY_W];
        end
      end
      if (cfg_info_hit) begin // R16
        st_nxt.conf = reg_wdata_i & pci_image_translate_cfg_gen_pkg::CONFIG_CYCLE_INFO_WMASK; // R12
      end
    end

    // Register reads; unmapped and reserved locations read as zero.
    if (reg_rd_i) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        if (image_hit[i]) begin
          st_nxt.rdata = {st_r.translation_field[i], 8'h00, st_r.mqual[i], 1'b0};
        end
      end
      if (cfg_info_hit) begin // R16
        st_nxt.rdata = st_r.conf;
      end
    end

    // Configuration cycle address phase from the data register access.
    if ((reg_wr_i || reg_rd_i) && cfg_data_hit) begin // R16 R18
      if (st_r.conf[pci_image_translate_cfg_gen_pkg::CYCLE_TYPE_BIT]) begin
        cfg_word = st_r.conf; // R13
      end else begin
        cfg_word = idsel; // R14
        cfg_word[10:8] = st_r.conf[pci_image_translate_cfg_gen_pkg::FUNCTION_NUMBER_LSB +:
                                   pci_image_translate_cfg_gen_pkg::FUNCTION_NUMBER_W]; // R15
        cfg_word[7:2] = st_r.conf[pci_image_translate_cfg_gen_pkg::REGISTER_NUMBER_LSB +:
                                  pci_image_translate_cfg_gen_pkg::REGISTER_NUMBER_W]; // R15
        cfg_word[1:0] = 2'b00; // R15
      end
      st_nxt.cstart = 1'b1; // R18
      st_nxt.cwrite = reg_wr_i; // R18
      st_nxt.ctype1 = st_r.conf[pci_image_translate_cfg_gen_pkg::CYCLE_TYPE_BIT]; // R13
      st_nxt.caddr = cfg_word;
    end

    // Image decode of a primary-bus cycle.
    if (dec_req_i) begin
      translation_field_sel = st_r.translation_field[dec_image_i]; // R8
      mq_sel = st_r.mqual[dec_image_i];
      mem_mode = !(dest_is_pci_i && command_mode_i); // R2
      if (translation_enable_i) begin
        sub_addr = (dec_addr_i & ~block_mask) | ({translation_field_sel, 16'h0000} & block_mask); // R7
      end else begin
        sub_addr = dec_addr_i;
      end
      if (dec_master_i >= pci_image_translate_cfg_gen_pkg::FIRST_SHARED_MASTER) begin
        pair_on_primary = (dec_master_i == 3'h5) ? shared_pair5_assign_i :
                          (dec_master_i == 3'h6) ? shared_pair6_assign_i :
                          shared_pair7_assign_i; // R11
      end
      if (primary_arbiter_enable_i && master_decode_enable_i &&
          dec_master_i != 3'h0) begin // R10
        qualified = mq_sel[dec_master_i - 3'h1] && pair_on_primary; // R9 R11
      end
      st_nxt.dvalid = 1'b1;
      st_nxt.claim = qualified;
      st_nxt.daddr = sub_addr;
      st_nxt.io_cmd = !mem_mode && !four_byte_read_i; // R3 R4
      st_nxt.burst_ok = mem_mode; // R2 R3
      st_nxt.max_bytes = mem_mode ? 4'h0 : pci_image_translate_cfg_gen_pkg::IO_MAX_BYTES; // R3
      st_nxt.min_read = mem_mode ? pci_image_translate_cfg_gen_pkg::MIN_READ_MEMORY :
                        four_byte_read_i ? pci_image_translate_cfg_gen_pkg::MIN_READ_MEM_IO :
                        4'h0; // R4
      st_nxt.pf_keep = mem_mode && prefetch_keep_i; // R5
      st_nxt.pf_resv = mem_mode &&
                       prefetch_amount_i > pci_image_translate_cfg_gen_pkg::PREFETCH_AMOUNT_LAST; // R6
      if (mem_mode && !st_nxt.pf_resv) begin // R5
        st_nxt.pf_bytes = pci_image_translate_cfg_gen_pkg::PREFETCH_BASE_BYTES
                          << prefetch_amount_i; // R6
      end else begin
        st_nxt.pf_bytes = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) begin
        st_r.translation_field[i] <= pci_image_translate_cfg_gen_pkg::TRANSLATION_FIELD_RST;
        st_r.mqual[i] <= pci_image_translate_cfg_gen_pkg::MASTER_QUALIFY_RST;
      end
      st_r.conf <= pci_image_translate_cfg_gen_pkg::CONFIG_CYCLE_INFO_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.rvalid <= 1'b0;
      st_r.dvalid <= 1'b0;
      st_r.claim <= 1'b0;
      st_r.daddr <= 32'h0000_0000;
      st_r.io_cmd <= 1'b0;
      st_r.burst_ok <= 1'b0;
      st_r.min_read <= 4'h0;
      st_r.max_bytes <= 4'h0;
      st_r.pf_keep <= 1'b0;
      st_r.pf_bytes <= 8'h00;
      st_r.pf_resv <= 1'b0;
      st_r.cstart <= 1'b0;
      st_r.cwrite <= 1'b0;
      st_r.ctype1 <= 1'b0;
      st_r.caddr <= 32'h0000_0000;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign reg_rvalid_o = st_r.rvalid;
  assign dec_valid_o = st_r.dvalid;
  assign dec_claim_o = st_r.claim;
  assign dec_addr_o = st_r.daddr;
  assign dec_io_cmd_o = st_r.io_cmd;
  assign dec_burst_ok_o = st_r.burst_ok;
  assign dec_min_read_o = st_r.min_read;
  assign dec_max_bytes_o = st_r.max_bytes;
  assign dec_prefetch_keep_o = st_r.pf_keep;
  assign dec_prefetch_bytes_o = st_r.pf_bytes;
  assign dec_prefetch_reserved_o = st_r.pf_resv;
  assign cfg_start_o = st_r.cstart;
  assign cfg_write_o = st_r.cwrite;
  assign cfg_type1_o = st_r.ctype1;
  assign cfg_addr_o = st_r.caddr;

endmodule

/* core/pci_image_translate_cfg_gen_pkg.sv */
package pci_image_translate_cfg_gen_pkg;

  // Register byte offsets.
  localparam logic [11:0] IMAGE0_TRANSLATION_ADDRESS_OFS = 12'h104;
  localparam logic [11:0] IMAGE1_TRANSLATION_ADDRESS_OFS = 12'h114;
  localparam logic [11:0] IMAGE2_TRANSLATION_ADDRESS_OFS = 12'h124;
  localparam logic [11:0] IMAGE3_TRANSLATION_ADDRESS_OFS = 12'h134;
  localparam logic [11:0] CONFIG_CYCLE_INFO_OFS = 12'h144;
  localparam logic [11:0] CONFIG_CYCLE_DATA_OFS = 12'h148;

  // Reset values.
  localparam logic [15:0] TRANSLATION_FIELD_RST = 16'h0000;
  localparam logic [6:0] MASTER_QUALIFY_RST = 7'h00;
  localparam logic [31:0] CONFIG_CYCLE_INFO_RST = 32'h0000_0000;

  // Translation address register layout.
  localparam int TRANSLATION_FIELD_LSB = 16;
  localparam int TRANSLATION_FIELD_W = 16;
  localparam int MASTER_QUALIFY_LSB = 1;
  localparam int MASTER_QUALIFY_W = 7;

  // Configuration cycle information layout.
  localparam int BUS_NUMBER_LSB = 16;
  localparam int BUS_NUMBER_W = 8;
  localparam int DEVICE_NUMBER_LSB = 11;
  localparam int DEVICE_NUMBER_W = 5;
  localparam int FUNCTION_NUMBER_LSB = 8;
  localparam int FUNCTION_NUMBER_W = 3;
  localparam int REGISTER_NUMBER_LSB = 2;
  localparam int REGISTER_NUMBER_W = 6;
  localparam int CYCLE_TYPE_BIT = 0;
  localparam logic [31:0] CONFIG_CYCLE_INFO_WMASK = 32'h00ff_fffd;

  // Address decode of an image.
  localparam int BLOCK_BASE_BIT = 16;
  localparam int IDSEL_LOW_BASE = 11;
  localparam int IDSEL_HIGH_BASE = 16;
  localparam logic [4:0] DEVICE_NUMBER_HIGH_FIRST = 5'h10;
  localparam logic [4:0] DEVICE_NUMBER_LAST = 5'h14;

  // Transaction sizes in bytes.
  localparam logic [3:0] MIN_READ_MEMORY = 4'h8;
  localparam logic [3:0] MIN_READ_MEM_IO = 4'h4;
  localparam logic [3:0] IO_MAX_BYTES = 4'h4;
  localparam logic [7:0] PREFETCH_BASE_BYTES = 8'h08;
  localparam logic [2:0] PREFETCH_AMOUNT_LAST = 3'h4;

  // Master numbers served by shared request and grant pairs.
  localparam logic [2:0] FIRST_SHARED_MASTER = 3'h5;

endpackage

/* tb/pci_image_translate_cfg_gen_assertions.sv */
`timescale 1ns/10ps
module pci_image_translate_cfg_gen_assertions (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_rvalid_o,
  input wire logic primary_arbiter_enable_i,
  input wire logic dec_req_i,
  input wire logic [31:0] dec_addr_i,
  input wire logic dest_is_pci_i,
  input wire logic command_mode_i,
  input wire logic four_byte_read_i,
  input wire logic [2:0] prefetch_amount_i,
  input wire logic translation_enable_i,
  input wire logic master_decode_enable_i,
  input wire logic dec_valid_o,
  input wire logic dec_claim_o,
  input wire logic [31:0] dec_addr_o,
  input wire logic dec_io_cmd_o,
  input wire logic dec_burst_ok_o,
  input wire logic [3:0] dec_min_read_o,
  input wire logic [3:0] dec_max_bytes_o,
  input wire logic dec_prefetch_keep_o,
  input wire logic [7:0] dec_prefetch_bytes_o,
  input wire logic cfg_start_o,
  input wire logic cfg_write_o,
  input wire logic cfg_type1_o,
  input wire logic [31:0] cfg_addr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i || !ce_i);
  logic io;
  assign io = dest_is_pci_i && command_mode_i && !four_byte_read_i;
  chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
  chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray rvalid");
  chk_plain_claim: assert property (dec_req_i && !(primary_arbiter_enable_i &&
    master_decode_enable_i) |=> dec_valid_o && dec_claim_o) else $error("claim lost");
  chk_io_limits: assert property (dec_req_i && io |=> dec_io_cmd_o && !dec_burst_ok_o &&
    dec_max_bytes_o == 4'h4 && dec_prefetch_bytes_o == 8'h00 && !dec_prefetch_keep_o)
    else $error("io limits");
  chk_mem_mode: assert property (dec_req_i && !(dest_is_pci_i && command_mode_i) |=>
    !dec_io_cmd_o && dec_burst_ok_o && dec_min_read_o == 4'h8) else $error("mem mode");
  chk_mem_io_read: assert property (dec_req_i && dest_is_pci_i && command_mode_i &&
    four_byte_read_i |=> !dec_io_cmd_o && dec_min_read_o == 4'h4) else $error("4 byte read");
  chk_prefetch_size: assert property (dec_req_i && !(dest_is_pci_i && command_mode_i) &&
    prefetch_amount_i <= 3'h4 |=> dec_prefetch_bytes_o == (8'h08 << $past(prefetch_amount_i)))
    else $error("prefetch");
  chk_no_translate: assert property (dec_req_i && !translation_enable_i |=>
    dec_addr_o == $past(dec_addr_i)) else $error("address changed");
  chk_cfg_start: assert property ((reg_wr_i || reg_rd_i) && reg_addr_i == 12'h148 |=>
    cfg_start_o && cfg_write_o == $past(reg_wr_i)) else $error("no config cycle");
  chk_type0_lines: assert property (cfg_start_o && !cfg_type1_o |->
    cfg_addr_o[1:0] == 2'h0 && $onehot0(cfg_addr_o[31:11])) else $error("type 0 address");
  cover property (cfg_start_o && cfg_type1_o);
  cover property (cfg_start_o && !cfg_write_o);
  cover property (dec_valid_o && !dec_claim_o);
endmodule
bind pci_image_translate_cfg_gen pci_image_translate_cfg_gen_assertions u_chk (.*);

/* tb/secondary_cfg_target_model.sv */
`timescale 1ns/10ps
// Secondary-bus target that latches every configuration address phase.
module secondary_cfg_target_model (
  input wire logic clk_i,
  input wire logic cfg_start_i,
  input wire logic cfg_write_i,
  input wire logic [31:0] cfg_addr_i,
  output logic [32:0] seen_o,
  output int count_o
);
  initial begin
    seen_o = '0;
    count_o = 0;
  end
  always @(posedge clk_i) begin
    if (cfg_start_i) begin
      seen_o <= {cfg_write_i, cfg_addr_i};
      count_o <= count_o + 1;
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic gap = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic dec_req_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] dec_addr_i = 32'h0;
  logic [21:0] ctl = 22'h0;
  logic [31:0] reg_rdata_o, dec_addr_o, cfg_addr_o, seed, info;
  logic [31:0] tf[4];
  logic reg_rvalid_o, dec_valid_o, dec_claim_o, dec_io_cmd_o, dec_burst_ok_o;
  logic dec_prefetch_keep_o, dec_prefetch_reserved_o, cfg_start_o, cfg_write_o, cfg_type1_o;
  logic [3:0] dec_min_read_o, dec_max_bytes_o;
  logic [7:0] dec_prefetch_bytes_o;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int ncfg = 0;
  int seen_cnt;
  always #10 clk_i = ~clk_i;
  pci_image_translate_cfg_gen u_pci_image_translate_cfg_gen (.clk_i(clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .primary_arbiter_enable_i(ctl[0]), .shared_pair5_assign_i(ctl[1]),
    .shared_pair6_assign_i(ctl[2]), .shared_pair7_assign_i(ctl[3]), .dec_req_i(dec_req_i),
    .dec_image_i(ctl[5:4]), .dec_addr_i(dec_addr_i), .dec_master_i(ctl[8:6]),
    .image_block_size_i(ctl[12:9]), .dest_is_pci_i(ctl[13]), .command_mode_i(ctl[14]),
    .four_byte_read_i(ctl[15]), .prefetch_keep_i(ctl[16]), .prefetch_amount_i(ctl[19:17]),
    .translation_enable_i(ctl[20]), .master_decode_enable_i(ctl[21]),
    .dec_valid_o(dec_valid_o), .dec_claim_o(dec_claim_o), .dec_addr_o(dec_addr_o),
    .dec_io_cmd_o(dec_io_cmd_o), .dec_burst_ok_o(dec_burst_ok_o),
    .dec_min_read_o(dec_min_read_o), .dec_max_bytes_o(dec_max_bytes_o),
    .dec_prefetch_keep_o(dec_prefetch_keep_o), .dec_prefetch_bytes_o(dec_prefetch_bytes_o),
    .dec_prefetch_reserved_o(dec_prefetch_reserved_o), .cfg_start_o(cfg_start_o),
    .cfg_write_o(cfg_write_o), .cfg_type1_o(cfg_type1_o), .cfg_addr_o(cfg_addr_o));
  secondary_cfg_target_model u_secondary_cfg_target_model (.clk_i(clk_i),
    .cfg_start_i(cfg_start_o), .cfg_write_i(cfg_write_o), .cfg_addr_i(cfg_addr_o),
    .seen_o(), .count_o(seen_cnt));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] e;
    logic tr;
    tr = a[11:6] == 6'h04 && a[3:0] == 4'h4;
    e = a == 12'h144 ? info : tr ? tf[a[5:4]] : 32'h0;
    @(negedge clk_i);
    reg_wr_i = wr;
    reg_rd_i = !wr;
    reg_addr_i = a;
    reg_wdata_i = d;
    if (gap) begin
      ce_i = 1'b0;
      @(negedge clk_i);
      chk({reg_rvalid_o, cfg_start_o}, 2'b00);
      ce_i = 1'b1;
    end
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    if (!wr) chk({reg_rvalid_o, reg_rdata_o}, {1'b1, e});
    if (wr && a == 12'h144) info = d & pci_image_translate_cfg_gen_pkg::CONFIG_CYCLE_INFO_WMASK;
    if (wr && tr) tf[a[5:4]] = d & 32'hffff_00fe;
  endtask
  task automatic cfg(input logic wr);
    logic [31:0] e;
    int d;
    d = info[15:11];
    e = d < 16 ? 32'h1 << (16 + d) : d < 21 ? 32'h1 << (d - 5) : 32'h0;
    e = info[0] ? info : e | {21'h0, info[10:2], 2'h0};
    acc(wr, 12'h148, rnd());
    chk({cfg_start_o, cfg_write_o, cfg_type1_o, cfg_addr_o}, {1'b1, wr, info[0], e});
    ncfg++;
  endtask
  task automatic dec();
    logic [31:0] r, mask, ea;
    logic io, cl, rs, mm;
    logic [2:0] a, m;
    r = rnd();
    @(negedge clk_i);
    ctl = r[21:0];
    dec_addr_i = rnd();
    dec_req_i = 1'b1;
    @(negedge clk_i);
    dec_req_i = 1'b0;
    a = ctl[19:17];
    m = ctl[8:6];
    io = ctl[13] && ctl[14] && !ctl[15];
    mm = !(ctl[13] && ctl[14]);
    rs = mm && a > 3'h4;
    mask = 32'hffff_ffff << (16 + ctl[12:9]);
    ea = ctl[20] ? (dec_addr_i & ~mask) | (tf[ctl[5:4]] & mask) : dec_addr_i;
    cl = !(ctl[0] && ctl[21] && m != 3'h0) || (tf[ctl[5:4]][m] && (m < 3'h5 || ctl[m - 3'h4]));
    chk(dec_addr_o, ea);
    chk({dec_valid_o, dec_claim_o, dec_io_cmd_o, dec_burst_ok_o,
      dec_min_read_o, dec_max_bytes_o, dec_prefetch_keep_o, dec_prefetch_reserved_o,
      dec_prefetch_bytes_o}, {1'b1, cl, io, mm, io ? 4'h0 : mm ? 4'h8 : 4'h4,
      mm ? 4'h0 : 4'h4, mm && ctl[16], rs, (!mm || rs) ? 8'h00 : 8'h08 << a});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'h7d04;
    info = 32'h0;
    for (int i = 0; i < 4; i++) tf[i] = 32'h0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 5; i++) acc(1'b0, 12'h104 + 12'(16 * i), 32'h0);
    acc(1'b0, 12'h200, 32'h0);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 12'h104 + 12'(16 * i), rnd());
      acc(1'b0, 12'h104 + 12'(16 * i), 32'h0);
    end
    for (int d = 0; d < 36; d++) begin
      seed = rnd();
      acc(1'b1, 12'h144, {seed[31:16], 5'(d), seed[10:1], d > 31});
      cfg(seed[0]);
    end
    gap = 1'b1;
    cfg(1'b1);
    cfg(1'b0);
    gap = 1'b0;
    repeat (300) begin
      if (rnd() % 4 == 0) acc(1'b1, 12'h104 + {6'h0, seed[5:4], 4'h0}, rnd());
      dec();
    end
    @(negedge clk_i);
    chk(seen_cnt, ncfg);
    give_verdict();
  end
endmodule
